// [bench/mesdc_host_model.sv]
`timescale 1ns/1ns
module mesdc_host_model
  import mesdc_pkg::*;
(
  input wire logic clk_sys_i,     // System clock
  output logic [7:0] reg_addr_o,  // Register address
  output logic reg_wr_o,          // Write strobe
  output logic [7:0] reg_wdata_o, // Write data
  output logic reg_rd_o,          // Read strobe
  input wire logic [7:0] reg_rdata_i, // Read data
  input wire logic reg_hit_i      // Block answered
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o = 1'b0;
  end

  // Released lines show the inverse so stale values never look valid
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clk_sys_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic h);
    @(negedge clk_sys_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clk_sys_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
    h = reg_hit_i;
  endtask
endmodule

// [bench/motion_event_status_and_data_config_tb.sv]
`timescale 1ns/1ns
`define CHK(w, e, g) check(w, e, g)
module motion_event_status_and_data_config_tb
  import mesdc_pkg::*;
;
  localparam logic [41:0] RAW = 42'h2AAAAAAAAAA;
  localparam logic [41:0] HPD = 42'h15555555555;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr, wdata, rdata, enable, limit, wmask, status, d;
  logic wr, rd, hit, h, active, slp_en, tick, fovf;
  logic trn, ori, tap, ffm, snew, sovw, tlp, hrate;
  logic [5:0] cnt, thr;
  logic [41:0] out_s, tap_s;
  logic [1:0] rng, cut, mode;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;

  always #20 clk_sys_i = ~clk_sys_i;

  mesdc_host_model mesdc_host_model_inst (
    .clk_sys_i(clk_sys_i), .reg_addr_o(addr), .reg_wr_o(wr),
    .reg_wdata_o(wdata), .reg_rd_o(rd), .reg_rdata_i(rdata),
    .reg_hit_i(hit));

  mesdc_top mesdc_top_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .reg_hit_o(hit), .event_enable_i(enable),
    .active_i(active), .sleep_enable_i(slp_en),
    .sleep_inactivity_limit_i(limit), .wake_source_mask_i(wmask),
    .sample_tick_i(tick), .fifo_overflow_i(fovf),
    .fifo_sample_count_i(cnt), .fifo_threshold_i(thr),
    .transient_active_i(trn), .orientation_changed_flag_i(ori),
    .tap_active_i(tap), .freefall_motion_active_i(ffm),
    .sample_new_flag_i(snew), .sample_overwrite_flag_i(sovw),
    .raw_sample_i(RAW), .hp_sample_i(HPD), .out_sample_o(out_s),
    .tap_sample_o(tap_s), .tap_lowpass_enable_o(tlp),
    .range_select_o(rng), .cutoff_select_o(cut), .system_mode_o(mode),
    .high_rate_o(hrate), .event_source_status_o(status));

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Hang guard, well above the roughly 150 cycles the tests need
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      summarize();
    end
  end

  task automatic check(input string w, input logic [47:0] e,
                       input logic [47:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  task automatic done(input string w);
    $display("test %s done", w);
  endtask

  task automatic set_src(input int b, input logic v);
    @(negedge clk_sys_i);
    case (b)
      5: trn = v;
      4: ori = v;
      3: tap = v;
      default: ffm = v;
    endcase
  endtask

  function automatic logic [7:0] clr_addr(input int b);
    case (b)
      5: return ADDR_TRANSIENT_SOURCE;
      4: return ADDR_ORIENTATION_STATUS;
      3: return ADDR_TAP_SOURCE;
      default: return ADDR_FREEFALL_MOTION_SOURCE;
    endcase
  endfunction

  task automatic rd_chk(input string w, input logic [7:0] a,
                        input logic [7:0] e, input logic eh);
    mesdc_host_model_inst.read_reg(a, d, h);
    `CHK(w, e, d);
    `CHK("hit", eh, h);
  endtask

  task automatic wr_rd(input logic [7:0] a, input logic [7:0] v,
                       input logic [7:0] e);
    mesdc_host_model_inst.write_reg(a, v);
    rd_chk("readback", a, e, 1'b1);
  endtask

  initial begin
    {enable, limit, wmask} = {8'hFF, 8'h03, 8'h00};
    {active, slp_en, tick, fovf} = 4'b1000;
    {trn, ori, tap, ffm, snew, sovw} = 6'b000000;
    cnt = 6'h00;
    thr = 6'h3F;
    idle(2);
    rst_i = 1'b0;
    idle(2);
    `CHK("mode", MODE_CODE_WAKE, mode);
    rd_chk("data cfg", ADDR_OUTPUT_DATA_CONFIG, 8'h00, 1'b1);
    rd_chk("hp cfg", ADDR_HIGHPASS_CUTOFF_CONFIG, 8'h00, 1'b1);
    `CHK("range", RANGE_2G, rng);
    `CHK("out data", RAW, out_s);
    wr_rd(ADDR_DEVICE_IDENTITY, 8'hFF, 8'h5C);
    rd_chk("unmapped", 8'h40, 8'h00, 1'b0);
    done("reset and identity");
    wr_rd(ADDR_OUTPUT_DATA_CONFIG, 8'hFF, 8'h10);
    `CHK("range kept", RANGE_2G, rng);
    idle(1);
    `CHK("out hp", HPD, out_s);
    for (int c = 0; c < 3; c++) begin
      wr_rd(ADDR_OUTPUT_DATA_CONFIG, 8'(c), 8'(c));
      `CHK("range code", c[1:0], rng);
    end
    `CHK("out raw", RAW, out_s);
    wr_rd(ADDR_HIGHPASS_CUTOFF_CONFIG, 8'hFF, 8'h33);
    idle(1);
    `CHK("tap lp", 1'b1, tlp);
    `CHK("tap raw", RAW, tap_s);
    for (int c = 0; c < 4; c++) begin
      wr_rd(ADDR_HIGHPASS_CUTOFF_CONFIG, 8'(c), 8'(c));
      `CHK("cutoff", c[1:0], cut);
    end
    idle(1);
    `CHK("tap lp off", 1'b0, tlp);
    `CHK("tap hp", HPD, tap_s);
    done("configuration");
    for (int b = 2; b < 6; b++) begin
      set_src(b, 1'b1);
      idle(2);
      `CHK("flag set", 1'b1, status[b]);
      mesdc_host_model_inst.read_reg(clr_addr(b), d, h);
      idle(1);
      `CHK("flag cleared", 1'b0, status[b]);
      idle(2);
      `CHK("no re-set on level", 1'b0, status[b]);
      set_src(b, 1'b0);
    end
    enable = 8'hDF;
    set_src(5, 1'b1);
    idle(2);
    `CHK("disabled source", 1'b0, status[5]);
    set_src(5, 1'b0);
    enable = 8'hFF;
    done("event flags");
    cnt = 6'h05;
    thr = 6'h05;
    idle(2);
    `CHK("fifo threshold", 1'b1, status[6]);
    rd_chk("fifo status read", ADDR_FIFO_STATUS, 8'h00, 1'b0);
    idle(1);
    `CHK("fifo cleared", 1'b0, status[6]);
    cnt = 6'h00;
    idle(1);
    fovf = 1'b1;
    idle(2);
    `CHK("fifo overflow", 1'b1, status[6]);
    mesdc_host_model_inst.read_reg(ADDR_FIFO_STATUS, d, h);
    fovf = 1'b0;
    idle(1);
    `CHK("fifo cleared again", 1'b0, status[6]);
    done("fifo");
    for (int k = 0; k < 2; k++) begin
      snew = (k == 0);
      sovw = (k == 1);
      idle(2);
      `CHK("sample ready", 1'b1, status[0]);
      rd_chk("status reg", ADDR_EVENT_SOURCE_STATUS, 8'h01, 1'b1);
      mesdc_host_model_inst.read_reg(ADDR_OUT_X_MSB + 8'(k), d, h);
      mesdc_host_model_inst.read_reg(ADDR_OUT_Y_MSB + 8'(k), d, h);
      idle(1);
      `CHK("still ready", 1'b1, status[0]);
      mesdc_host_model_inst.read_reg(ADDR_OUT_Z_MSB + 8'(k), d, h);
      idle(1);
      `CHK("ready cleared", 1'b0, status[0]);
      {snew, sovw} = 2'b00;
      idle(1);
    end
    done("sample ready");
    slp_en = 1'b1;
    wmask = 8'h08;
    for (int t = 0; t < 4; t++) begin
      `CHK("still awake", MODE_CODE_WAKE, mode);
      @(negedge clk_sys_i);
      tick = 1'b1;
      @(negedge clk_sys_i);
      tick = 1'b0;
    end
    `CHK("asleep", MODE_CODE_SLEEP, mode);
    `CHK("low rate", 1'b0, hrate);
    `CHK("sleep flag", 1'b1, status[7]);
    rd_chk("mode read", ADDR_SYSTEM_MODE, 8'h00, 1'b0);
    idle(1);
    `CHK("sleep flag cleared", 1'b0, status[7]);
    set_src(3, 1'b1);
    idle(2);
    `CHK("woken", MODE_CODE_WAKE, mode);
    `CHK("high rate", 1'b1, hrate);
    rd_chk("status reg", ADDR_EVENT_SOURCE_STATUS, 8'h88, 1'b1);
    set_src(3, 1'b0);
    slp_en = 1'b0;
    done("sleep and wake");
    mesdc_host_model_inst.read_reg(ADDR_SYSTEM_MODE, d, h);
    active = 1'b0;
    idle(2);
    `CHK("standby", MODE_CODE_STANDBY, mode);
    active = 1'b1;
    idle(2);
    `CHK("standby exit", MODE_CODE_WAKE, mode);
    `CHK("no flag on exit", 1'b0, status[7]);
    done("standby");
    summarize();
  end
endmodule

// [src/mesdc_event_flags.sv]
`timescale 1ns/1ns
module mesdc_event_flags
  import mesdc_pkg::*;
(
  input wire logic clk_sys_i, // System clock
  input wire logic rst_i,     // Asynchronous reset, active high
  mesdc_flag_if.core fl       // Conditions, clears and flags
);
  logic [7:0] cond_q;
  logic [7:0] flags;
  logic [7:0] next_cond_q;
  logic [7:0] next_flags;
  logic [7:0] rise;

  always_comb begin
    next_cond_q = fl.cond & EVENT_IMPLEMENTED_MASK;
    rise = next_cond_q & ~cond_q;
    // Set beats a clear arriving in the same cycle
    next_flags = rise | (flags & ~fl.clr);
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cond_q <= 8'h00;
      flags <= 8'h00;
    end else begin
      cond_q <= next_cond_q;
      flags <= next_flags;
    end
  end

  assign fl.rise = rise;
  assign fl.flags = flags;

  a_flag_rise_sets: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (rise != 8'h00) |=> ((flags & $past(rise)) == $past(rise)))
    else $error("event flag missed its rising condition");

  a_flag_holds_uncleared: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (flags[BIT_FIFO] && !fl.clr[BIT_FIFO]) |=> flags[BIT_FIFO])
    else $error("fifo event flag dropped without a clearing read");
endmodule

// [src/mesdc_flag_if.sv]
`timescale 1ns/1ns
interface mesdc_flag_if;
  logic [7:0] cond;
  logic [7:0] clr;
  logic [7:0] rise;
  logic [7:0] flags;
  modport core (input cond, input clr, output rise, output flags);
  modport user (output cond, output clr, input rise, input flags);
endinterface

// [src/mesdc_pkg.sv]
package mesdc_pkg;
  // Register map
  localparam logic [7:0] ADDR_FIFO_STATUS = 8'h00;
  localparam logic [7:0] ADDR_OUT_X_MSB = 8'h01;
  localparam logic [7:0] ADDR_OUT_X_LSB = 8'h02;
  localparam logic [7:0] ADDR_OUT_Y_MSB = 8'h03;
  localparam logic [7:0] ADDR_OUT_Y_LSB = 8'h04;
  localparam logic [7:0] ADDR_OUT_Z_MSB = 8'h05;
  localparam logic [7:0] ADDR_OUT_Z_LSB = 8'h06;
  localparam logic [7:0] ADDR_SYSTEM_MODE = 8'h0B;
  localparam logic [7:0] ADDR_EVENT_SOURCE_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_DEVICE_IDENTITY = 8'h0D;
  localparam logic [7:0] ADDR_OUTPUT_DATA_CONFIG = 8'h0E;
  localparam logic [7:0] ADDR_HIGHPASS_CUTOFF_CONFIG = 8'h0F;
  localparam logic [7:0] ADDR_ORIENTATION_STATUS = 8'h10;
  localparam logic [7:0] ADDR_FREEFALL_MOTION_SOURCE = 8'h16;
  localparam logic [7:0] ADDR_TRANSIENT_SOURCE = 8'h1E;
  localparam logic [7:0] ADDR_TAP_SOURCE = 8'h22;

  // Event status bit positions
  localparam int unsigned BIT_SLEEP_WAKE = 7;
  localparam int unsigned BIT_FIFO = 6;
  localparam int unsigned BIT_TRANSIENT = 5;
  localparam int unsigned BIT_ORIENTATION = 4;
  localparam int unsigned BIT_TAP = 3;
  localparam int unsigned BIT_FREEFALL_MOTION = 2;
  localparam int unsigned BIT_SAMPLE_READY = 0;
  localparam logic [7:0] EVENT_IMPLEMENTED_MASK = 8'hFD;
  localparam logic [7:0] ACTIVITY_MASK = 8'h7D;

  // Configuration fields
  localparam logic [7:0] OUTPUT_DATA_CONFIG_MASK = 8'h13;
  localparam logic [7:0] HIGHPASS_CUTOFF_CONFIG_MASK = 8'h33;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam int unsigned HIGHPASS_OUTPUT_SELECT_BIT = 4;
  localparam int unsigned RANGE_SELECT_LSB = 0;
  localparam int unsigned TAP_HIGHPASS_BYPASS_BIT = 5;
  localparam int unsigned TAP_LOWPASS_ENABLE_BIT = 4;
  localparam int unsigned CUTOFF_SELECT_LSB = 0;
  localparam logic [1:0] RANGE_2G = 2'h0;
  localparam logic [1:0] RANGE_4G = 2'h1;
  localparam logic [1:0] RANGE_8G = 2'h2;
  localparam logic [1:0] RANGE_RESERVED = 2'h3;

  // System mode codes
  localparam logic [1:0] MODE_CODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_CODE_WAKE = 2'h1;
  localparam logic [1:0] MODE_CODE_SLEEP = 2'h2;

  localparam int unsigned SAMPLE_W = 14;
  localparam int unsigned AXES = 3;
  localparam int unsigned DATA_W = SAMPLE_W * AXES;
  localparam logic [7:0] IDLE_COUNT_ZERO = 8'h00;
  localparam logic [7:0] IDLE_COUNT_STEP = 8'h01;

  typedef enum logic [1:0] {
    MESDC_STANDBY,
    MESDC_WAKE,
    MESDC_SLEEP
  } mesdc_mode_t;
endpackage

// [src/mesdc_top.sv]
`timescale 1ns/1ns
// Behaviour
// - Sleep/wake flag sets on wake/sleep transition, not on standby entry or exit
// - Wake to sleep after inactivity limit
// - Sleep to wake on selected wake event
// - System mode read clears sleep/wake flag
// - FIFO flag on overflow or threshold match
// - FIFO status read clears FIFO flag
// - Transient flag follows event-active; source read clears
// - Orientation flag follows change; status read clears
// - Tap flag follows event-active; source read clears
// - Freefall/motion flag follows event-active; read clears
// - Sample-ready flag on new or overwrite
// - Sample-ready clears only after X, Y, Z reads
// - Read-only identity register ignores writes
// - Highpass select feeds filtered data out
// - Range codes 2g, 4g, 8g; 11 reserved
// - Reset gives 2g, raw data out and highpass data to tap
// - Two-bit cutoff select in bits 1:0
// - Tap highpass bypass and lowpass enable
// - Flags set on rising edge, held till read
module mesdc_top
  import mesdc_pkg::*;
#(
  parameter logic [7:0] DEVICE_IDENTITY_VALUE = 8'h5C // Arbitrary value
) (
  input wire logic clk_sys_i,                 // System clock
  input wire logic rst_i,                     // Async reset, high
  input wire logic [7:0] reg_addr_i,          // Register address
  input wire logic reg_wr_i,                  // Write strobe
  input wire logic [7:0] reg_wdata_i,         // Write data
  input wire logic reg_rd_i,                  // Read strobe
  output logic [7:0] reg_rdata_o,             // Read data, next cycle
  output logic reg_hit_o,                     // This block answered
  input wire logic [7:0] event_enable_i,      // Per-source enables
  input wire logic active_i,                  // Device in active state
  input wire logic sleep_enable_i,            // Auto-sleep allowed
  input wire logic [7:0] sleep_inactivity_limit_i, // Idle ticks
  input wire logic [7:0] wake_source_mask_i,  // Wake event select
  input wire logic sample_tick_i,             // One pulse per sample
  input wire logic fifo_overflow_i,           // FIFO full overflow
  input wire logic [5:0] fifo_sample_count_i, // FIFO occupancy
  input wire logic [5:0] fifo_threshold_i,    // FIFO threshold
  input wire logic transient_active_i,        // Transient event-active
  input wire logic orientation_changed_flag_i, // Orientation changed
  input wire logic tap_active_i,              // Tap event-active
  input wire logic freefall_motion_active_i,  // Freefall/motion active
  input wire logic sample_new_flag_i,         // New XYZ sample
  input wire logic sample_overwrite_flag_i,   // XYZ sample overwritten
  input wire logic [DATA_W-1:0] raw_sample_i, // Unfiltered XYZ
  input wire logic [DATA_W-1:0] hp_sample_i,  // Highpass XYZ
  output logic [DATA_W-1:0] out_sample_o,     // To data regs and FIFO
  output logic [DATA_W-1:0] tap_sample_o,     // To tap processing
  output logic tap_lowpass_enable_o,          // Tap lowpass on
  output logic [1:0] range_select_o,          // Full-scale code
  output logic [1:0] cutoff_select_o,         // Highpass cutoff code
  output logic [1:0] system_mode_o,           // Standby/wake/sleep
  output logic high_rate_o,                   // High sample rate chosen
  output logic [7:0] event_source_status_o    // Event flags
);
  mesdc_flag_if fl ();

  mesdc_event_flags u_flags (
    .clk_sys_i (clk_sys_i),
    .rst_i (rst_i),
    .fl (fl)
  );

  mesdc_mode_t mode;
  mesdc_mode_t next_mode;
  logic [7:0] idle_cnt;
  logic [7:0] next_idle_cnt;
  logic [7:0] data_cfg;
  logic [7:0] next_data_cfg;
  logic [7:0] hp_cfg;
  logic [7:0] next_hp_cfg;
  logic [2:0] axis_seen;
  logic [2:0] next_axis_seen;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic hit;
  logic next_hit;
  logic [DATA_W-1:0] out_sample;
  logic [DATA_W-1:0] next_out_sample;
  logic [DATA_W-1:0] tap_sample;
  logic [DATA_W-1:0] next_tap_sample;
  logic activity;
  logic wake_event;
  logic mode_switch;
  logic fifo_cond;
  logic [2:0] axis_rd;
  logic xyz_done;
  logic [1:0] wr_range;

  // Event conditions and clearing reads
  always_comb begin
    fifo_cond = fifo_overflow_i
      || (fifo_sample_count_i == fifo_threshold_i);
    fl.cond = 8'h00;
    fl.cond[BIT_SLEEP_WAKE] = mode_switch
      && event_enable_i[BIT_SLEEP_WAKE];
    fl.cond[BIT_FIFO] = fifo_cond && event_enable_i[BIT_FIFO];
    fl.cond[BIT_TRANSIENT] = transient_active_i
      && event_enable_i[BIT_TRANSIENT];
    fl.cond[BIT_ORIENTATION] = orientation_changed_flag_i
      && event_enable_i[BIT_ORIENTATION];
    fl.cond[BIT_TAP] = tap_active_i && event_enable_i[BIT_TAP];
    fl.cond[BIT_FREEFALL_MOTION] = freefall_motion_active_i
      && event_enable_i[BIT_FREEFALL_MOTION];
    fl.cond[BIT_SAMPLE_READY] = (sample_new_flag_i
      || sample_overwrite_flag_i)
      && event_enable_i[BIT_SAMPLE_READY];
    axis_rd[0] = reg_rd_i && (reg_addr_i == ADDR_OUT_X_MSB
      || reg_addr_i == ADDR_OUT_X_LSB);
    axis_rd[1] = reg_rd_i && (reg_addr_i == ADDR_OUT_Y_MSB
      || reg_addr_i == ADDR_OUT_Y_LSB);
    axis_rd[2] = reg_rd_i && (reg_addr_i == ADDR_OUT_Z_MSB
      || reg_addr_i == ADDR_OUT_Z_LSB);
    xyz_done = &(axis_seen | axis_rd);
    next_axis_seen = xyz_done ? 3'h0 : (axis_seen | axis_rd);
    fl.clr = 8'h00;
    fl.clr[BIT_SLEEP_WAKE] = reg_rd_i
      && reg_addr_i == ADDR_SYSTEM_MODE;
    fl.clr[BIT_FIFO] = reg_rd_i && reg_addr_i == ADDR_FIFO_STATUS;
    fl.clr[BIT_TRANSIENT] = reg_rd_i
      && reg_addr_i == ADDR_TRANSIENT_SOURCE;
    fl.clr[BIT_ORIENTATION] = reg_rd_i
      && reg_addr_i == ADDR_ORIENTATION_STATUS;
    fl.clr[BIT_TAP] = reg_rd_i && reg_addr_i == ADDR_TAP_SOURCE;
    fl.clr[BIT_FREEFALL_MOTION] = reg_rd_i
      && reg_addr_i == ADDR_FREEFALL_MOTION_SOURCE;
    fl.clr[BIT_SAMPLE_READY] = xyz_done;
  end

  // Auto sleep/wake sequencing
  always_comb begin
    activity = (fl.rise & ACTIVITY_MASK) != 8'h00;
    wake_event = (fl.rise & wake_source_mask_i & ACTIVITY_MASK) != 8'h00;
    next_mode = mode;
    next_idle_cnt = idle_cnt;
    if (!active_i) begin
      next_mode = MESDC_STANDBY;
      next_idle_cnt = IDLE_COUNT_ZERO;
    end else begin
      unique case (mode)
        MESDC_STANDBY: begin
          next_mode = MESDC_WAKE;
          next_idle_cnt = IDLE_COUNT_ZERO;
        end
        MESDC_WAKE: begin
          if (activity || !sleep_enable_i) begin
            next_idle_cnt = IDLE_COUNT_ZERO;
          end else if (sample_tick_i) begin
            if (idle_cnt == sleep_inactivity_limit_i) begin
              next_mode = MESDC_SLEEP;
              next_idle_cnt = IDLE_COUNT_ZERO;
            end else begin
              next_idle_cnt = idle_cnt + IDLE_COUNT_STEP;
            end
          end
        end
        MESDC_SLEEP: begin
          if (wake_event || !sleep_enable_i) begin
            next_mode = MESDC_WAKE;
          end
        end
      endcase
    end
    mode_switch = (mode == MESDC_WAKE && next_mode == MESDC_SLEEP)
      || (mode == MESDC_SLEEP && next_mode == MESDC_WAKE);
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mode <= MESDC_STANDBY;
      idle_cnt <= IDLE_COUNT_ZERO;
    end else begin
      mode <= next_mode;
      idle_cnt <= next_idle_cnt;
    end
  end

  // Register file and readback
  always_comb begin
    next_data_cfg = data_cfg;
    next_hp_cfg = hp_cfg;
    wr_range = reg_wdata_i[RANGE_SELECT_LSB +: 2];
    if (reg_wr_i && reg_addr_i == ADDR_OUTPUT_DATA_CONFIG) begin
      next_data_cfg = reg_wdata_i & OUTPUT_DATA_CONFIG_MASK;
      if (wr_range == RANGE_RESERVED) begin
        next_data_cfg[RANGE_SELECT_LSB +: 2] =
          data_cfg[RANGE_SELECT_LSB +: 2];
      end
    end
    if (reg_wr_i && reg_addr_i == ADDR_HIGHPASS_CUTOFF_CONFIG) begin
      next_hp_cfg = reg_wdata_i & HIGHPASS_CUTOFF_CONFIG_MASK;
    end
    next_hit = 1'b0;
    next_rdata = 8'h00;
    if (reg_rd_i) begin
      next_hit = 1'b1;
      unique case (reg_addr_i)
        ADDR_EVENT_SOURCE_STATUS: next_rdata = fl.flags;
        ADDR_DEVICE_IDENTITY: next_rdata = DEVICE_IDENTITY_VALUE;
        ADDR_OUTPUT_DATA_CONFIG: next_rdata = data_cfg;
        ADDR_HIGHPASS_CUTOFF_CONFIG: next_rdata = hp_cfg;
        default: next_hit = 1'b0;
      endcase
    end
    next_out_sample = data_cfg[HIGHPASS_OUTPUT_SELECT_BIT]
      ? hp_sample_i : raw_sample_i;
    next_tap_sample = hp_cfg[TAP_HIGHPASS_BYPASS_BIT]
      ? raw_sample_i : hp_sample_i;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      data_cfg <= CONFIG_RESET;
      hp_cfg <= CONFIG_RESET;
      axis_seen <= 3'h0;
      rdata <= 8'h00;
      hit <= 1'b0;
      out_sample <= '0;
      tap_sample <= '0;
    end else begin
      data_cfg <= next_data_cfg;
      hp_cfg <= next_hp_cfg;
      axis_seen <= next_axis_seen;
      rdata <= next_rdata;
      hit <= next_hit;
      out_sample <= next_out_sample;
      tap_sample <= next_tap_sample;
    end
  end

  always_comb begin
    unique case (mode)
      MESDC_STANDBY: system_mode_o = MODE_CODE_STANDBY;
      MESDC_WAKE: system_mode_o = MODE_CODE_WAKE;
      MESDC_SLEEP: system_mode_o = MODE_CODE_SLEEP;
      default: system_mode_o = MODE_CODE_STANDBY;
    endcase
  end

  assign high_rate_o = (mode == MESDC_WAKE);
  assign reg_rdata_o = rdata;
  assign reg_hit_o = hit;
  assign out_sample_o = out_sample;
  assign tap_sample_o = tap_sample;
  assign tap_lowpass_enable_o = hp_cfg[TAP_LOWPASS_ENABLE_BIT];
  assign range_select_o = data_cfg[RANGE_SELECT_LSB +: 2];
  assign cutoff_select_o = hp_cfg[CUTOFF_SELECT_LSB +: 2];
  assign event_source_status_o = fl.flags;

  sequence s_read_x;
    reg_rd_i && axis_rd[0] && axis_seen == 3'h0;
  endsequence
  sequence s_read_y;
    reg_rd_i && axis_rd[1];
  endsequence
  sequence s_read_z;
    reg_rd_i && axis_rd[2];
  endsequence

  a_sleep_entry: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (mode == MESDC_WAKE && active_i && sleep_enable_i && !activity
      && sample_tick_i && idle_cnt == sleep_inactivity_limit_i)
    |=> (mode == MESDC_SLEEP && !high_rate_o))
    else $error("sleep not entered at inactivity limit");

  a_wake_entry: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (mode == MESDC_SLEEP && active_i && wake_event)
    |=> (mode == MESDC_WAKE && high_rate_o))
    else $error("wake not entered on wake event");

  a_mode_flag_set: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (active_i && $past(active_i) && mode != $past(mode)
      && $past(mode) != MESDC_STANDBY && event_enable_i[BIT_SLEEP_WAKE]
      && $past(event_enable_i[BIT_SLEEP_WAKE]))
    |-> fl.flags[BIT_SLEEP_WAKE])
    else $error("sleep/wake flag not set on transition");

  a_sysmode_clear: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == ADDR_SYSTEM_MODE
      && !fl.rise[BIT_SLEEP_WAKE] && !mode_switch)
    |=> !fl.flags[BIT_SLEEP_WAKE])
    else $error("system mode read left sleep/wake flag set");

  a_fifo_flag_set: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (event_enable_i[BIT_FIFO] && fifo_overflow_i
      && !$past(fifo_cond)) |=> fl.flags[BIT_FIFO])
    else $error("fifo flag not set on overflow");

  a_drdy_survives_status: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (fl.flags[BIT_SAMPLE_READY] && axis_seen == 3'h0
      && reg_rd_i && reg_addr_i == ADDR_EVENT_SOURCE_STATUS)
    |=> fl.flags[BIT_SAMPLE_READY])
    else $error("sample-ready cleared by status read");

  a_drdy_xyz_clear: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (!fl.rise[BIT_SAMPLE_READY]) throughout
      (s_read_x ##[2:3] s_read_y ##[2:3] s_read_z)
    |=> !fl.flags[BIT_SAMPLE_READY])
    else $error("sample-ready not cleared after X, Y, Z reads");

  a_identity_read: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == ADDR_DEVICE_IDENTITY)
    |=> (reg_hit_o && reg_rdata_o == DEVICE_IDENTITY_VALUE))
    else $error("identity register read wrong");

  a_config_fixed_zero: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (data_cfg & ~OUTPUT_DATA_CONFIG_MASK) == 8'h00
    && (hp_cfg & ~HIGHPASS_CUTOFF_CONFIG_MASK) == 8'h00)
    else $error("fixed-zero config bit set");

  a_hpf_output_select: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    data_cfg[HIGHPASS_OUTPUT_SELECT_BIT]
    |=> out_sample_o == $past(hp_sample_i))
    else $error("highpass data not selected");

  a_range_reserved: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    range_select_o != RANGE_RESERVED)
    else $error("reserved range code stored");
endmodule
